// ==== design/slu_top.v ====
// Purpose: Digital core of a dual line sensor transceiver with link UART
// Assumes: APB slave on pclk, line inputs synchronous to pclk
// Notes:   Overload inputs come from the analog current limiters
`timescale 1ns/1ps
`default_nettype none
`include "slu_regs.vh"
module slu_top #(
    parameter CLK_HZ = `SLU_CLK_HZ,
    parameter MAX_SEQ = `SLU_MAX_SEQ
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         irq,
    input  wire        cq_line_in,
    output reg         cq_line_out,
    output reg         cq_line_oe,
    input  wire        aux_line_io_in,
    output reg         aux_line_io_out,
    output reg         aux_line_io_oe,
    input  wire        aux_direct_drive_in,
    input  wire        cq_ovl,
    input  wire        aux_ovl
);
    localparam integer DIV2_FULL = CLK_HZ / (`SLU_COM2_BAUD * `SLU_OVS);
    localparam integer DIV3_FULL = CLK_HZ / (`SLU_COM3_BAUD * `SLU_OVS);
    localparam [15:0]  DIV2      = DIV2_FULL[15:0];
    localparam [15:0]  DIV3      = DIV3_FULL[15:0];

    reg [31:0]            ctrl;
    reg [`SLU_ST_W-1:0]   stat;
    reg [`SLU_ST_W-1:0]   mask;
    reg [7:0]             buf_mem [0:MAX_SEQ-1];
    reg [3:0]             seq_len;
    reg [3:0]             wr_idx;
    reg [7:0]             cksum;
    reg [7:0]             rx_last;
    reg [15:0]            div_cnt;
    reg                   tick;
    reg                   link_active;
    reg                   tx_load;
    reg [7:0]             tx_byte;
    reg [`SLU_ST_W-1:0]   next_stat;
    reg                   tx_busy_q;

    wire [1:0] mode    = ctrl[`SLU_CTRL_MODE_HI:`SLU_CTRL_MODE_LO];
    wire [1:0] cq_drv  = ctrl[`SLU_CTRL_CQ_HI:`SLU_CTRL_CQ_LO];
    wire [1:0] aux_drv = ctrl[`SLU_CTRL_AUX_HI:`SLU_CTRL_AUX_LO];
    wire       wr_en   = psel && penable && pwrite;
    wire       rd_en   = psel && !penable && !pwrite;
    wire [7:0] rx_byte;
    wire       rx_valid;
    wire       rx_perr;
    wire       tx_out;
    wire       tx_busy;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function is_buf;
        input [11:0] a;
        begin
            is_buf = (a >= `SLU_ADDR_BUF0) && (a <= `SLU_ADDR_BUF_LAST)
                     && (a[1:0] == 2'h0);
        end
    endfunction

    function [1:0] drive;
        input [1:0] m;
        input       v;
        begin
            case (m)
                `SLU_DRV_HS: drive = {v, 1'b1};
                `SLU_DRV_LS: drive = {~v, 1'b0};
                `SLU_DRV_PP: drive = {1'b1, v};
                default:     drive = 2'h0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Baud tick, crystal free, from core clock
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 16'h0000;
            tick    <= 1'b0;
        end else if (div_cnt == 16'h0000) begin
            div_cnt <= ctrl[`SLU_CTRL_COM3] ? DIV3 - 16'h0001 : DIV2 - 16'h0001;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt - 16'h0001;
            tick    <= 1'b0;
        end
    end

    slu_uart_rx u_rx (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick     (tick),
        .rx_in    (cq_line_in),
        .rx_byte  (rx_byte),
        .rx_valid (rx_valid),
        .rx_perr  (rx_perr)
    );

    slu_uart_tx u_tx (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .load    (tx_load),
        .data    (tx_byte),
        .tx_out  (tx_out),
        .busy    (tx_busy)
    );

    // ------------------------------------------------------------------
    // Transmit end detection for the done event
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_busy_q <= 1'b0;
        end else begin
            tx_busy_q <= tx_busy;
        end
    end

    // ------------------------------------------------------------------
    // Status event collection, set wins over clear
    // ------------------------------------------------------------------
    always @* begin
        next_stat = stat;
        if (wr_en && paddr == `SLU_ADDR_STAT) begin
            next_stat = stat & ~pwdata[`SLU_ST_W-1:0];
        end
        if (rx_valid && mode == `SLU_MODE_TRANSP) begin
            next_stat[`SLU_ST_OCTET] = 1'b1;
        end
        if (rx_valid && mode == `SLU_MODE_SINGLE) begin
            next_stat[`SLU_ST_OCTET] = 1'b1;
            next_stat[`SLU_ST_PERR]  = next_stat[`SLU_ST_PERR] | rx_perr;
        end
        if (rx_valid && mode == `SLU_MODE_MULTI) begin
            next_stat[`SLU_ST_PERR] = next_stat[`SLU_ST_PERR] | rx_perr;
            if (wr_idx + 4'h1 == seq_len) begin
                next_stat[`SLU_ST_SEQ]   = 1'b1;
                next_stat[`SLU_ST_CKERR] = next_stat[`SLU_ST_CKERR]
                                           | ((cksum ^ rx_byte) != `SLU_CK_SEED);
            end
        end
        if (cq_ovl) begin
            next_stat[`SLU_ST_CQ_OVL] = 1'b1;
        end
        if (aux_ovl) begin
            next_stat[`SLU_ST_AUX_OVL] = 1'b1;
        end
        if (tx_busy_q && !tx_busy) begin
            next_stat[`SLU_ST_TXDONE] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers, receive buffer and APB
    // ------------------------------------------------------------------
    integer i;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl        <= `SLU_CTRL_RESET;
            stat        <= {`SLU_ST_W{1'b0}};
            mask        <= {`SLU_ST_W{1'b0}};
            seq_len     <= 4'h0;
            wr_idx      <= 4'h0;
            cksum       <= `SLU_CK_SEED;
            rx_last     <= 8'h00;
            link_active <= 1'b0;
            tx_load     <= 1'b0;
            tx_byte     <= 8'h00;
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            irq         <= 1'b0;
            for (i = 0; i < MAX_SEQ; i = i + 1) begin
                buf_mem[i] <= 8'h00;
            end
        end else begin
            stat    <= next_stat;
            irq     <= |(next_stat & mask);
            tx_load <= 1'b0;
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (rx_valid) begin
                rx_last     <= rx_byte;
                link_active <= 1'b1;
                if (mode == `SLU_MODE_MULTI) begin
                    buf_mem[wr_idx] <= rx_byte;
                    if (wr_idx + 4'h1 == seq_len) begin
                        wr_idx <= 4'h0;
                        cksum  <= `SLU_CK_SEED;
                    end else begin
                        wr_idx <= wr_idx + 4'h1;
                        cksum  <= cksum ^ rx_byte;
                    end
                end
            end
            if (wr_en) begin
                case (paddr)
                    `SLU_ADDR_CTRL:   ctrl <= pwdata;
                    `SLU_ADDR_MASK:   mask <= pwdata[`SLU_ST_W-1:0];
                    `SLU_ADDR_SEQLEN: begin
                        if (pwdata[3:0] != 4'h0) begin
                            seq_len <= pwdata[3:0];
                        end
                        wr_idx <= 4'h0;
                        cksum  <= `SLU_CK_SEED;
                    end
                    `SLU_ADDR_TXDATA: begin
                        tx_byte <= pwdata[7:0];
                        tx_load <= 1'b1;
                    end
                    `SLU_ADDR_LINE:   link_active <= pwdata[0];
                    `SLU_ADDR_STAT:   ;
                    default:          ;
                endcase
            end
            if (rd_en) begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    `SLU_ADDR_CTRL:   prdata <= ctrl;
                    `SLU_ADDR_STAT:   prdata <= {25'h0, stat};
                    `SLU_ADDR_MASK:   prdata <= {25'h0, mask};
                    `SLU_ADDR_RXDATA: prdata <= {24'h0, rx_last};
                    `SLU_ADDR_SEQLEN: prdata <= {24'h0, wr_idx, seq_len};
                    `SLU_ADDR_LINE:   prdata <= {28'h0, tx_busy, aux_line_io_in,
                                                 cq_line_in, link_active};
                    default: begin
                        if (is_buf(paddr)) begin
                            prdata <= {24'h0, buf_mem[paddr[5:2]]};
                        end
                    end
                endcase
            end
            if (psel && !penable && !pwrite && paddr != `SLU_ADDR_CTRL
                && paddr != `SLU_ADDR_STAT && paddr != `SLU_ADDR_MASK
                && paddr != `SLU_ADDR_RXDATA && paddr != `SLU_ADDR_SEQLEN
                && paddr != `SLU_ADDR_LINE && !is_buf(paddr)) begin
                pslverr <= 1'b1;
            end
            if (psel && !penable && pwrite && paddr != `SLU_ADDR_CTRL
                && paddr != `SLU_ADDR_STAT && paddr != `SLU_ADDR_MASK
                && paddr != `SLU_ADDR_TXDATA && paddr != `SLU_ADDR_SEQLEN
                && paddr != `SLU_ADDR_LINE) begin
                pslverr <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Line output stages
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cq_line_out     <= 1'b0;
            cq_line_oe      <= 1'b0;
            aux_line_io_out <= 1'b0;
            aux_line_io_oe  <= 1'b0;
        end else begin
            if (link_active && tx_busy) begin
                {cq_line_oe, cq_line_out} <= {1'b1, tx_out};
            end else if (link_active) begin
                {cq_line_oe, cq_line_out} <= 2'h0;
            end else begin
                {cq_line_oe, cq_line_out} <= drive(cq_drv, ctrl[`SLU_CTRL_CQ_VAL]);
            end
            {aux_line_io_oe, aux_line_io_out} <=
                drive(aux_drv, aux_direct_drive_in | ctrl[`SLU_CTRL_AUX_VAL]);
        end
    end
endmodule // slu_top
`default_nettype wire

// ==== include/slu_regs.vh ====
// Purpose: Register map and constants of the sensor link UART front end
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef SLU_REGS_VH
`define SLU_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SLU_ADDR_CTRL      12'h000
`define SLU_ADDR_STAT      12'h004
`define SLU_ADDR_MASK      12'h008
`define SLU_ADDR_TXDATA    12'h00C
`define SLU_ADDR_RXDATA    12'h010
`define SLU_ADDR_SEQLEN    12'h014
`define SLU_ADDR_LINE      12'h018
`define SLU_ADDR_BUF0      12'h040
`define SLU_ADDR_BUF_LAST  12'h078

// ----------------------------------------------------------------------
// CTRL fields
// ----------------------------------------------------------------------
`define SLU_CTRL_MODE_LO   0
`define SLU_CTRL_MODE_HI   1
`define SLU_CTRL_COM3      2
`define SLU_CTRL_CQ_LO     4
`define SLU_CTRL_CQ_HI     5
`define SLU_CTRL_AUX_LO    6
`define SLU_CTRL_AUX_HI    7
`define SLU_CTRL_CQ_VAL    8
`define SLU_CTRL_AUX_VAL   9
`define SLU_CTRL_RESET     32'h0000_0000

// UART modes
`define SLU_MODE_TRANSP    2'h0
`define SLU_MODE_SINGLE    2'h1
`define SLU_MODE_MULTI     2'h2

// Output stage modes
`define SLU_DRV_HIZ        2'h0
`define SLU_DRV_HS         2'h1
`define SLU_DRV_LS         2'h2
`define SLU_DRV_PP         2'h3

// ----------------------------------------------------------------------
// STAT / MASK bits
// ----------------------------------------------------------------------
`define SLU_ST_OCTET       0
`define SLU_ST_SEQ         1
`define SLU_ST_PERR        2
`define SLU_ST_CKERR       3
`define SLU_ST_CQ_OVL      4
`define SLU_ST_AUX_OVL     5
`define SLU_ST_TXDONE      6
`define SLU_ST_W           7

// ----------------------------------------------------------------------
// Link timing
// ----------------------------------------------------------------------
`define SLU_CLK_HZ         40000000
`define SLU_COM2_BAUD      38400
`define SLU_COM3_BAUD      230400
`define SLU_OVS            16
`define SLU_MAX_SEQ        15
`define SLU_CK_SEED        8'h52

`endif

// ==== design/slu_uart_rx.v ====
// Purpose: Line receiver, 1 start, 8 data LSB first, even parity, 1 stop
// Assumes: Sample tick at 16x baud, line input already synchronous
// Notes:   Timing taken from the start edge, no crystal reference
`timescale 1ns/1ps
`default_nettype none
`include "slu_regs.vh"
module slu_uart_rx (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       tick,
    input  wire       rx_in,
    output reg  [7:0] rx_byte,
    output reg        rx_valid,
    output reg        rx_perr
);
    localparam IDLE = 2'h0;
    localparam DATA = 2'h1;
    localparam STOP = 2'h2;

    reg [1:0] state;
    reg [3:0] phase;
    reg [3:0] nbit;
    reg [8:0] shift;

    // ------------------------------------------------------------------
    // Bit recovery from start edge
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= IDLE;
            phase    <= 4'h0;
            nbit     <= 4'h0;
            shift    <= 9'h000;
            rx_byte  <= 8'h00;
            rx_valid <= 1'b0;
            rx_perr  <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (tick) begin
                case (state)
                    IDLE: begin
                        if (!rx_in) begin
                            state <= DATA;
                            phase <= 4'h8;
                            nbit  <= 4'h0;
                        end
                    end
                    DATA: begin
                        phase <= phase + 4'h1;
                        if (phase == 4'hF) begin
                            if (nbit == 4'h0 && rx_in) begin
                                state <= IDLE;
                            end else if (nbit != 4'h0) begin
                                shift <= {rx_in, shift[8:1]};
                            end
                            nbit <= nbit + 4'h1;
                            if (nbit == 4'h9) begin
                                state <= STOP;
                            end
                        end
                    end
                    STOP: begin
                        phase <= phase + 4'h1;
                        if (phase == 4'hF) begin
                            state    <= IDLE;
                            rx_byte  <= shift[7:0];
                            rx_perr  <= (^shift) | ~rx_in;
                            rx_valid <= 1'b1;
                        end
                    end
                    default: state <= IDLE;
                endcase
            end
        end
    end
endmodule // slu_uart_rx
`default_nettype wire

// ==== design/slu_uart_tx.v ====
// Purpose: Line transmitter, 1 start, 8 data LSB first, even parity, 1 stop
// Assumes: Sample tick at 16x baud
// Notes:   busy stays high from load to end of stop bit
`timescale 1ns/1ps
`default_nettype none
`include "slu_regs.vh"
module slu_uart_tx (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       tick,
    input  wire       load,
    input  wire [7:0] data,
    output reg        tx_out,
    output reg        busy
);
    reg [10:0] frame;
    reg [3:0]  phase;
    reg [3:0]  nbit;

    // ------------------------------------------------------------------
    // Frame shifter
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame  <= 11'h7FF;
            phase  <= 4'h0;
            nbit   <= 4'h0;
            tx_out <= 1'b1;
            busy   <= 1'b0;
        end else if (load && !busy) begin
            frame <= {1'b1, ^data, data, 1'b0};
            phase <= 4'h0;
            nbit  <= 4'h0;
            busy  <= 1'b1;
        end else if (busy && tick) begin
            tx_out <= frame[0];
            phase  <= phase + 4'h1;
            if (phase == 4'hF) begin
                frame <= {1'b1, frame[10:1]};
                nbit  <= nbit + 4'h1;
                if (nbit == 4'hA) begin
                    busy <= 1'b0;
                end
            end
        end
    end
endmodule // slu_uart_tx
`default_nettype wire

// ==== verif/slu_top_sva.sv ====
// Purpose: Bus and interrupt checks on slu_top ports
// Assumes: One clock pclk, presetn async active low
// Notes:   Bound to every slu_top instance
`timescale 1ns/1ps
`default_nettype none
module slu_top_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire clr_wr = psel && penable && pwrite && pready
                  && (paddr == 12'h004 || paddr == 12'h008);
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_err_unmapped: assert property (pready && paddr > 12'h078 |-> pslverr)
        else $error("unmapped access accepted");
    chk_err_mapped: assert property (pready && paddr <= 12'h018 && paddr[1:0] == 2'b00
                                     |-> !pslverr)
        else $error("mapped access refused");
    chk_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    chk_irq_hold: assert property ($fell(irq) |-> $past(clr_wr) || $past(clr_wr, 2))
        else $error("irq fell without service");
endmodule // slu_top_sva
bind slu_top slu_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
                                .prdata, .pready, .pslverr, .irq);
`default_nettype wire

// ==== verif/slu_link_master.sv ====
// Purpose: Link master on the cable line, COM3 timing
// Assumes: Line idle high, bit length in pclk set by the bench
// Notes:   Tasks are called from the testbench
`timescale 1ns/1ps
`default_nettype none
module slu_link_master (
    input wire logic pclk,
    input wire logic line,
    output var logic drive
);
    localparam int BIT = 160;
    int bit_cyc = BIT;
    initial drive = 1'b1;
    // Master starts every exchange except in the transmit test, where the device sends first
    task automatic send_octet(input logic [7:0] d, input logic bad);
        logic [10:0] f;
        f = {1'b1, ^d ^ bad, d, 1'b0};
        @(posedge pclk);
        for (int i = 0; i < 11; i++) begin
            drive <= f[i];
            repeat (bit_cyc) @(posedge pclk);
        end
    endtask
    task automatic get_octet(output logic [7:0] d, output logic par);
        int n;
        n = 0;
        while (line !== 1'b0 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        repeat (bit_cyc / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge pclk);
            d[i] = line;
        end
        repeat (bit_cyc) @(posedge pclk);
        par = line;
    endtask
endmodule // slu_link_master
`default_nettype wire

// ==== verif/tb_sensor_link_uart_frontend.sv ====
// Purpose: Self-checking bench for slu_top
// Assumes: COM2 and COM3 link rates, APB slave answers when ready
// Notes:   Seeded random octets and register values
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_link_uart_frontend;
    logic        pclk, presetn, psel, penable, pwrite, err, p;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic        pready, pslverr, irq, m_drive;
    logic        cq_line_out, cq_line_oe, aux_line_io_out, aux_line_io_oe;
    logic        aux_direct_drive_in, cq_ovl, aux_ovl;
    logic [7:0]  b, x, q [0:14];
    int          n_mismatch, total_checks, seed;
    wire         cq_wire = cq_line_oe ? cq_line_out : m_drive;
    wire         aux_wire = aux_line_io_oe ? aux_line_io_out : 1'b0;
    // ------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------
    slu_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
                 .prdata, .pready, .pslverr, .irq, .cq_line_in(cq_wire),
                 .cq_line_out, .cq_line_oe, .aux_line_io_in(aux_wire),
                 .aux_line_io_out, .aux_line_io_oe, .aux_direct_drive_in,
                 .cq_ovl, .aux_ovl);
    slu_link_master u_master (.pclk, .line(cq_wire), .drive(m_drive));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    function automatic logic [31:0] ctrl_val(input int m, input logic [7:0] r);
        return {22'h0, r[1], 1'b1, m[1:0], m[1:0], 1'b0, r[6], 2'(m % 3)};
    endfunction
    function automatic logic [1:0] drv_exp(input int m, input logic v);
        case (m)
            1: return {v, 1'b1};
            2: return {~v, 1'b0};
            3: return {1'b1, v};
            default: return 2'b00;
        endcase
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #2000000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        seed = 28982;
        {psel, penable, pwrite, cq_ovl, aux_ovl, aux_direct_drive_in} = '0;
        paddr = '0;
        pwdata = '0;
        n_mismatch = 0;
        total_checks = 0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        xfer(12'h000, 1'b0, 32'h0);
        check(rd, 32'h0);
        xfer(12'h100, 1'b0, 32'h0);
        check({rd, err}, {32'h0, 1'b1});
        for (int m = 0; m < 4; m++) begin
            x = 8'($random(seed));
            v = ctrl_val(m, x);
            xfer(12'h000, 1'b1, v);
            xfer(12'h000, 1'b0, 32'h0);
            check(rd, v);
            check({cq_line_oe, cq_line_out}, drv_exp(m, 1'b1));
            if (m == 3) begin
                aux_direct_drive_in <= 1'b1;
                repeat (4) @(posedge pclk);
                check({aux_line_io_oe, aux_line_io_out}, 2'b11);
                aux_direct_drive_in <= 1'b0;
                repeat (4) @(posedge pclk);
                check({aux_line_io_oe, aux_line_io_out}, {1'b1, x[1]});
            end
        end
        $display("config test done");
        xfer(12'h008, 1'b1, 32'h10);
        cq_ovl <= 1'b1;
        @(posedge pclk);
        cq_ovl <= 1'b0;
        aux_ovl <= 1'b1;
        @(posedge pclk);
        aux_ovl <= 1'b0;
        repeat (20) @(posedge pclk);
        check(irq, 1'b1);
        xfer(12'h004, 1'b0, 32'h0);
        check(rd & 32'h30, 32'h30);
        xfer(12'h004, 1'b1, 32'h10);
        repeat (3) @(posedge pclk);
        check(irq, 1'b0);
        xfer(12'h004, 1'b1, 32'h7F);
        $display("overload test done");
        xfer(12'h008, 1'b1, 32'h5);
        xfer(12'h000, 1'b1, 32'h5);
        for (int i = 0; i < 4; i++) begin
            b = 8'($random(seed));
            u_master.send_octet(b, i == 3);
            wait_irq(400);
            check(irq, 1'b1);
            xfer(12'h004, 1'b0, 32'h0);
            check(rd[2], i == 3);
            if (i < 3) begin
                xfer(12'h010, 1'b0, 32'h0);
                check(rd[7:0], b);
            end
            xfer(12'h004, 1'b1, 32'h7F);
        end
        $display("single octet test done");
        xfer(12'h000, 1'b1, 32'h0);
        u_master.bit_cyc = 1040;
        b = 8'($random(seed));
        u_master.send_octet(b, 1'b1);
        wait_irq(400);
        check(irq, 1'b1);
        xfer(12'h004, 1'b0, 32'h0);
        check(rd[2:0], 3'b001);
        xfer(12'h010, 1'b0, 32'h0);
        check(rd[7:0], b);
        xfer(12'h004, 1'b1, 32'h7F);
        u_master.bit_cyc = 160;
        $display("transparent test done");
        xfer(12'h008, 1'b1, 32'h2);
        xfer(12'h000, 1'b1, 32'h6);
        xfer(12'h014, 1'b1, 32'hF);
        x = 8'h0;
        for (int i = 0; i < 15; i++) begin
            q[i] = (i == 14) ? x : 8'($random(seed));
            x = x ^ q[i];
            u_master.send_octet(q[i], 1'b0);
            repeat (4) @(posedge pclk);
            check(irq, i == 14);
        end
        for (int i = 0; i < 15; i++) begin
            xfer(12'h040 + 12'(4 * i), 1'b0, 32'h0);
            check(rd[7:0], q[i]);
        end
        xfer(12'h004, 1'b0, 32'h0);
        check(rd[3], 1'b0);
        xfer(12'h004, 1'b1, 32'h7F);
        xfer(12'h014, 1'b1, 32'h1);
        b = 8'($random(seed)) | 8'h01;
        u_master.send_octet(b, 1'b0);
        wait_irq(400);
        xfer(12'h004, 1'b0, 32'h0);
        check(rd[3:1], 3'b101);
        xfer(12'h004, 1'b1, 32'h7F);
        $display("multi octet test done");
        b = 8'($random(seed));
        fork
            u_master.get_octet(x, p);
            xfer(12'h00C, 1'b1, {24'h0, b});
        join
        check({p, x}, {^b, b});
        repeat (300) @(posedge pclk);
        xfer(12'h004, 1'b0, 32'h0);
        check(rd[6], 1'b1);
        $display("transmit test done");
        tally_and_finish();
    end
endmodule // tb_sensor_link_uart_frontend
`default_nettype wire
